// file: hdl/dma_rd_defs.svh
// Constants for the DMA burst-read port state machine
`ifndef DMA_RD_DEFS_SVH
`define DMA_RD_DEFS_SVH
`define DMA_RD_SYNC_STAGES   3
`define DMA_RD_STROBE_OFF    1'b1
`define DMA_RD_STROBE_ON     1'b0
`define DMA_RD_REQ_OFF       1'b1
`define DMA_RD_REQ_ON        1'b0
`define DMA_RD_PIN_IDLE      3'h7
`define DMA_RD_ADDR_SELECT_N_BIT      0
`define DMA_RD_TARGET_READY_N_BIT      1
`define DMA_RD_COMM_BIT      2
`endif

// file: hdl/dma_rd_pkg.sv
// Types shared by the DMA burst-read port state machine
package dma_rd_pkg;
    // Gray steps along AD1 -> ATA -> DRD -> DWT -> LAST_TRANSFER_STATE -> CU -> ATW
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h00,
        ST_AD1    = 5'h01,
        ST_ATA    = 5'h03,
        ST_DRD    = 5'h02,
        ST_DWT    = 5'h06,
        ST_LTX    = 5'h07,
        ST_CU     = 5'h05,
        ST_ATW    = 5'h04,
        ST_AD2    = 5'h0c,
        ST_TS_AD1 = 5'h0d,
        ST_TS_ATA = 5'h0f,
        ST_TS_DRD = 5'h0e,
        ST_TS_DWT = 5'h0a,
        ST_TS_LTX = 5'h0b,
        ST_TS_CU  = 5'h09,
        ST_TS_ATW = 5'h08,
        ST_TS_AD2 = 5'h18
    } rd_state_t;

    // One DMA read command
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] bytes;
    } dma_cmd_t;

    // Port pins driven by the device
    typedef struct packed {
        logic [31:0] bus;
        logic        bus_oe;
        logic        capture_strobe_n;
        logic        final_transfer_n;
        logic        strobe_oe;
    } port_out_t;
endpackage

// file: hdl/dma_rd_xfer_count.sv
// Byte counter that raises last_next before the final read beat
`timescale 1ns/1ps
`default_nettype none
module dma_rd_xfer_count #(
    parameter int CNT_W = 16,
    parameter int BEAT  = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             arst_n_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_bytes_i,
    input  wire logic             capture_i,
    output logic                  last_next_o
);
    localparam logic [CNT_W-1:0] BEAT_C  = CNT_W'(BEAT);
    localparam logic [CNT_W-1:0] BEAT2_C = CNT_W'(2 * BEAT);

    logic [CNT_W-1:0] rem_q;
    logic [CNT_W-1:0] rem_d;

    generate
        if (BEAT < 1 || 2 * BEAT >= (1 << CNT_W)) begin : g_bad
            $error("dma_rd_xfer_count: beat size does not fit the counter");
        end
    endgenerate

    // Bytes still to arrive; a short tail counts as one beat
    always_comb begin
        rem_d = rem_q;
        if (load_i) begin
            rem_d = load_bytes_i;
        end else if (capture_i) begin
            rem_d = (rem_q > BEAT_C) ? rem_q - BEAT_C : '0;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rem_q <= '0;
        end else begin
            rem_q <= rem_d;
        end
    end

    // last from count
    // A capturing cycle already consumes one beat, so look one further
    assign last_next_o = capture_i ? (rem_q <= BEAT2_C) : (rem_q <= BEAT_C);
endmodule
`default_nettype wire

// file: hdl/dma_rd_port_fsm.sv
// Burst-read state machine of a multiplexed address/data DMA port
// Overview of operation
// - Select low, ready high: float, tri-state variant
// - Both low before turnaround: first address
// - Both low after turnaround: second address
// - First address, go: automatic turnaround, floated
// - No request then: turnaround-wait instead
// - Go from read-side states: read or last
// - Data read captures; last drives final-transfer low
// - Both high from read-side states: data wait
// - Wait then ready: read or last
// - Last transfer with select high always followed by clean-up
// - Clean-up or last-transfer tri-state, go: turnaround-wait
// - Both high keeps turnaround-wait; ready proceeds
// - Listed tri-states, go: automatic turnaround
// - Last-next comes from the byte count
// - Request while active; queued output when waiting
// - Drop request in clean-up; re-raise after if a command is queued
`timescale 1ns/1ps
`default_nettype none
`include "dma_rd_defs.svh"
module dma_rd_port_fsm #(
    parameter int DATA_W = 32,
    parameter int CNT_W  = 16
) (
    input  wire logic                 mclk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 addr_select_n_i,
    input  wire logic                 target_ready_n_i,
    input  wire logic                 comm_register_select_i,
    input  wire logic [DATA_W-1:0]    port_addr_data_bus_i,
    output logic [DATA_W-1:0]         port_addr_data_bus_o,
    output logic                      port_addr_data_bus_oe_o,
    output logic                      capture_strobe_n_o,
    output logic                      final_transfer_n_o,
    output logic                      strobe_oe_o,
    output logic                      dma_request_n_o,
    output logic                      queued_request_n_o,
    input  wire dma_rd_pkg::dma_cmd_t cmd_i,
    input  wire logic                 cmd_valid_i,
    output logic                      cmd_ready_o,
    output logic [DATA_W-1:0]         rd_data_o,
    output logic                      rd_valid_o,
    output logic                      rd_last_o
);
    localparam logic [31:0] BEAT_C = 32'(DATA_W / 8);

    generate
        if (DATA_W != 32 || CNT_W > 16 || CNT_W < 4) begin : g_bad
            $error("dma_rd_port_fsm: bus must be 32 bits, count 4..16 bits to fit the byte field");
        end
    endgenerate

    // Three-stage pin synchroniser, change taken when stages 2 and 3 agree
    logic [2:0] s1_q, s2_q, s3_q, pin_q;
    logic [2:0] s1_d, s2_d, s3_d, pin_d;
    always_comb begin
        s1_d = {comm_register_select_i, target_ready_n_i, addr_select_n_i};
        s2_d = s1_q;
        s3_d = s2_q;
        pin_d = pin_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q  <= `DMA_RD_PIN_IDLE;
            s2_q  <= `DMA_RD_PIN_IDLE;
            s3_q  <= `DMA_RD_PIN_IDLE;
            pin_q <= `DMA_RD_PIN_IDLE;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            pin_q <= pin_d;
        end
    end

    logic addr_select_n_n, target_ready_n_n, comm;
    assign addr_select_n_n = pin_q[`DMA_RD_ADDR_SELECT_N_BIT];
    assign target_ready_n_n = pin_q[`DMA_RD_TARGET_READY_N_BIT];
    assign comm   = pin_q[`DMA_RD_COMM_BIT];

    // Tri-state variant that remembers where the machine came from
    function automatic dma_rd_pkg::rd_state_t tri_of(input dma_rd_pkg::rd_state_t s);
        unique case (s)
            dma_rd_pkg::ST_AD1: tri_of = dma_rd_pkg::ST_TS_AD1;
            dma_rd_pkg::ST_AD2: tri_of = dma_rd_pkg::ST_TS_AD2;
            dma_rd_pkg::ST_ATA: tri_of = dma_rd_pkg::ST_TS_ATA;
            dma_rd_pkg::ST_DRD: tri_of = dma_rd_pkg::ST_TS_DRD;
            dma_rd_pkg::ST_DWT: tri_of = dma_rd_pkg::ST_TS_DWT;
            dma_rd_pkg::ST_LTX: tri_of = dma_rd_pkg::ST_TS_LTX;
            dma_rd_pkg::ST_CU:  tri_of = dma_rd_pkg::ST_TS_CU;
            dma_rd_pkg::ST_ATW: tri_of = dma_rd_pkg::ST_TS_ATW;
            default:            tri_of = s;
        endcase
    endfunction

    // Read-side states that step to data read or last transfer on go
    function automatic logic read_side(input dma_rd_pkg::rd_state_t s);
        read_side = s inside {dma_rd_pkg::ST_AD2, dma_rd_pkg::ST_ATA, dma_rd_pkg::ST_DRD,
                              dma_rd_pkg::ST_DWT, dma_rd_pkg::ST_TS_AD2, dma_rd_pkg::ST_TS_ATA,
                              dma_rd_pkg::ST_TS_DRD, dma_rd_pkg::ST_TS_DWT};
    endfunction

    dma_rd_pkg::rd_state_t state_q, state_d;
    logic                  post_q, post_d;
    logic                  last_next;
    logic                  act_q, act_d, que_q, que_d;
    dma_rd_pkg::dma_cmd_t  act_cmd_q, act_cmd_d, que_cmd_q, que_cmd_d;
    logic [31:0]           addr_q, addr_d;
    logic                  load;
    logic                  capture;

    // Next state from the synchronised strobes
    always_comb begin
        state_d = state_q;
        // comm select
        // A comm-register cycle is not ours; hold the DMA machine still
        if (!comm) begin
            if (!addr_select_n_n && target_ready_n_n) begin
                state_d = tri_of(state_q);
            end else if (!addr_select_n_n && !target_ready_n_n) begin
                state_d = post_q ? dma_rd_pkg::ST_AD2 : dma_rd_pkg::ST_AD1;
            end else if (addr_select_n_n && !target_ready_n_n) begin
                if (state_q == dma_rd_pkg::ST_AD1) begin
                    state_d = act_q ? dma_rd_pkg::ST_ATA : dma_rd_pkg::ST_ATW;
                end else if (read_side(state_q)) begin
                    state_d = last_next ? dma_rd_pkg::ST_LTX : dma_rd_pkg::ST_DRD;
                end else if (state_q == dma_rd_pkg::ST_LTX) begin
                    state_d = dma_rd_pkg::ST_CU;
                end else if (state_q inside {dma_rd_pkg::ST_CU, dma_rd_pkg::ST_TS_LTX}) begin
                    state_d = dma_rd_pkg::ST_ATW;
                end else if (state_q inside {dma_rd_pkg::ST_ATW, dma_rd_pkg::ST_TS_AD1,
                                             dma_rd_pkg::ST_TS_CU, dma_rd_pkg::ST_TS_ATW}) begin
                    state_d = dma_rd_pkg::ST_ATA;
                end
            end else begin
                if (state_q == dma_rd_pkg::ST_LTX) begin
                    state_d = dma_rd_pkg::ST_CU;
                end else if (state_q inside {dma_rd_pkg::ST_AD1, dma_rd_pkg::ST_ATW,
                                             dma_rd_pkg::ST_TS_AD1, dma_rd_pkg::ST_TS_ATW}) begin
                    state_d = dma_rd_pkg::ST_ATW;
                end else if (read_side(state_q) || state_q inside {dma_rd_pkg::ST_CU,
                             dma_rd_pkg::ST_TS_LTX, dma_rd_pkg::ST_TS_CU}) begin
                    state_d = dma_rd_pkg::ST_DWT;
                end
            end
        end
        // Post-turnaround span runs from turnaround to the last transfer
        post_d = post_q;
        if (state_d == dma_rd_pkg::ST_ATA) begin
            post_d = 1'b1;
        end else if (state_d == dma_rd_pkg::ST_LTX) begin
            post_d = 1'b0;
        end
    end

    assign capture = state_q inside {dma_rd_pkg::ST_DRD, dma_rd_pkg::ST_LTX};

    // Command slots: one active, one queued behind it
    always_comb begin
        act_d     = act_q;
        que_d     = que_q;
        act_cmd_d = act_cmd_q;
        que_cmd_d = que_cmd_q;
        addr_d    = capture ? addr_q + BEAT_C : addr_q;
        load      = 1'b0;
        // retire during clean-up, promote as it ends
        if (state_d == dma_rd_pkg::ST_CU && state_q != dma_rd_pkg::ST_CU) begin
            act_d = 1'b0;
        end
        if (state_q == dma_rd_pkg::ST_CU && state_d != dma_rd_pkg::ST_CU && que_q) begin
            act_d     = 1'b1;
            act_cmd_d = que_cmd_q;
            que_d     = 1'b0;
            load      = 1'b1;
        end else if (!act_q && state_q != dma_rd_pkg::ST_CU && que_q) begin
            act_d     = 1'b1;
            act_cmd_d = que_cmd_q;
            que_d     = 1'b0;
            load      = 1'b1;
        end
        if (cmd_valid_i && cmd_ready_o) begin
            que_d     = 1'b1;
            que_cmd_d = cmd_i;
        end
        if (load) begin
            addr_d = act_cmd_d.addr;
        end
    end

    // Only one command may wait; the source stalls beyond that
    assign cmd_ready_o = !que_q;

    dma_rd_xfer_count #(
        .CNT_W(CNT_W),
        .BEAT (DATA_W / 8)
    ) u_count (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .load_i      (load),
        .load_bytes_i(act_cmd_d.bytes[CNT_W-1:0]),
        .capture_i   (capture),
        .last_next_o (last_next)
    );

    // Pins shown in the next state, decoded ahead of the register
    dma_rd_pkg::port_out_t out_q, out_d;
    always_comb begin
        out_d.bus              = addr_d;
        out_d.bus_oe           = 1'b0;
        out_d.capture_strobe_n = `DMA_RD_STROBE_OFF;
        out_d.final_transfer_n = `DMA_RD_STROBE_OFF;
        out_d.strobe_oe        = 1'b1;
        unique case (state_d)
            dma_rd_pkg::ST_AD1, dma_rd_pkg::ST_AD2: out_d.bus_oe = 1'b1;
            dma_rd_pkg::ST_DRD: out_d.capture_strobe_n = `DMA_RD_STROBE_ON;
            dma_rd_pkg::ST_LTX: begin
                out_d.capture_strobe_n = `DMA_RD_STROBE_ON;
                out_d.final_transfer_n = `DMA_RD_STROBE_ON;
            end
            dma_rd_pkg::ST_TS_AD1, dma_rd_pkg::ST_TS_AD2, dma_rd_pkg::ST_TS_ATA,
            dma_rd_pkg::ST_TS_DRD, dma_rd_pkg::ST_TS_DWT, dma_rd_pkg::ST_TS_LTX,
            dma_rd_pkg::ST_TS_CU, dma_rd_pkg::ST_TS_ATW: out_d.strobe_oe = 1'b0;
            // Bus floated, strobes high; idle has no variant, so it floats them on select-without-ready
            default: out_d.strobe_oe = !(state_d == dma_rd_pkg::ST_IDLE && !comm && !addr_select_n_n && target_ready_n_n);
        endcase
    end

    // Captured read data and request levels
    logic [DATA_W-1:0] rd_data_d;
    logic              rd_valid_d, rd_last_d, req_n_d, qreq_n_d;
    always_comb begin
        rd_data_d  = capture ? port_addr_data_bus_i : rd_data_o;
        rd_valid_d = capture;
        rd_last_d  = state_q == dma_rd_pkg::ST_LTX;
        // request levels, low again after clean-up only when a queued command is promoted
        req_n_d    = (act_d && state_d != dma_rd_pkg::ST_CU) ? `DMA_RD_REQ_ON : `DMA_RD_REQ_OFF;
        qreq_n_d   = que_d ? `DMA_RD_REQ_ON : `DMA_RD_REQ_OFF;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q         <= dma_rd_pkg::ST_IDLE;
            post_q          <= 1'b0;
            act_q           <= 1'b0;
            que_q           <= 1'b0;
            act_cmd_q       <= '0;
            que_cmd_q       <= '0;
            addr_q          <= '0;
            out_q           <= '{bus: '0, bus_oe: 1'b0, capture_strobe_n: `DMA_RD_STROBE_OFF,
                                 final_transfer_n: `DMA_RD_STROBE_OFF, strobe_oe: 1'b1};
            rd_data_o       <= '0;
            rd_valid_o      <= 1'b0;
            rd_last_o       <= 1'b0;
            dma_request_n_o <= `DMA_RD_REQ_OFF;
            queued_request_n_o <= `DMA_RD_REQ_OFF;
        end else begin
            state_q         <= state_d;
            post_q          <= post_d;
            act_q           <= act_d;
            que_q           <= que_d;
            act_cmd_q       <= act_cmd_d;
            que_cmd_q       <= que_cmd_d;
            addr_q          <= addr_d;
            out_q           <= out_d;
            rd_data_o       <= rd_data_d;
            rd_valid_o      <= rd_valid_d;
            rd_last_o       <= rd_last_d;
            dma_request_n_o <= req_n_d;
            queued_request_n_o <= qreq_n_d;
        end
    end

    assign port_addr_data_bus_o    = out_q.bus;
    assign port_addr_data_bus_oe_o = out_q.bus_oe;
    assign capture_strobe_n_o      = out_q.capture_strobe_n;
    assign final_transfer_n_o      = out_q.final_transfer_n;
    assign strobe_oe_o             = out_q.strobe_oe;

    // Checks tying pin behaviour to the strobes that caused it
    a_tri_float: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && !addr_select_n_n && target_ready_n_n) |=> (!strobe_oe_o && !port_addr_data_bus_oe_o))
        else $error("outputs not floated on select-without-ready");
    a_first_addr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && !addr_select_n_n && !target_ready_n_n && !post_q) |=> (state_q == dma_rd_pkg::ST_AD1
        && port_addr_data_bus_oe_o && capture_strobe_n_o && final_transfer_n_o))
        else $error("first address state not entered");
    a_second_addr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && !addr_select_n_n && !target_ready_n_n && post_q) |=> (state_q == dma_rd_pkg::ST_AD2
        && port_addr_data_bus_oe_o))
        else $error("second address state not entered");
    a_auto_turn: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && addr_select_n_n && !target_ready_n_n && state_q == dma_rd_pkg::ST_AD1 && act_q)
        |=> (state_q == dma_rd_pkg::ST_ATA && !port_addr_data_bus_oe_o && capture_strobe_n_o))
        else $error("automatic turnaround missed");
    a_turn_wait: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && addr_select_n_n && !target_ready_n_n && state_q == dma_rd_pkg::ST_AD1 && !act_q)
        |=> state_q == dma_rd_pkg::ST_ATW)
        else $error("turnaround-wait missed without request");
    a_read_strobe: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (state_q == dma_rd_pkg::ST_LTX) |-> (!capture_strobe_n_o && !final_transfer_n_o)
        ##1 (rd_valid_o && rd_last_o))
        else $error("last transfer strobes or capture wrong");
    a_data_wait: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && addr_select_n_n && !target_ready_n_n == 1'b0 && state_q == dma_rd_pkg::ST_DRD)
        |=> (state_q == dma_rd_pkg::ST_DWT && capture_strobe_n_o) ##1 !rd_valid_o)
        else $error("data wait missed");
    a_cleanup_req: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && addr_select_n_n && state_q == dma_rd_pkg::ST_LTX)
        |=> (state_q == dma_rd_pkg::ST_CU && dma_request_n_o && capture_strobe_n_o))
        else $error("clean-up did not follow or request stayed low");
    a_wait_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (!comm && addr_select_n_n && target_ready_n_n && state_q == dma_rd_pkg::ST_ATW)[*2]
        |=> state_q == dma_rd_pkg::ST_ATW)
        else $error("turnaround-wait not held");
endmodule
`default_nettype wire

// file: verif/dma_rd_ctrl_model.sv
// Behavioural arbiter that steps the read port and drives read data
`timescale 1ns/1ps
`default_nettype none
module dma_rd_ctrl_model (
    input  wire logic        mclk_i,
    input  wire logic        bus_oe_i,
    input  wire logic [31:0] bus_dev_i,
    output logic             addr_select_n_o,
    output logic             target_ready_n_o,
    output logic             comm_register_select_o,
    output logic [31:0]      bus_o
);
    logic [15:0] beat_q = 16'h0000;

    // Strobes start released high, comm select low
    initial begin
        addr_select_n_o        = 1'b1;
        target_ready_n_o       = 1'b1;
        comm_register_select_o = 1'b0;
    end

    // New word every cycle, so a capture on the wrong edge shows as bad data
    always @(posedge mclk_i) begin
        beat_q <= beat_q + 16'h0001;
    end

    // Wire level: the device wins while it drives, else our changing word
    assign bus_o = bus_oe_i ? bus_dev_i : {16'hd0a7, beat_q};

    task set_pins(input logic addr_select_n_n, input logic target_ready_n_n, input logic comm);
        @(posedge mclk_i);
        addr_select_n_o        <= addr_select_n_n;
        target_ready_n_o       <= target_ready_n_n;
        comm_register_select_o <= comm;
    endtask
endmodule
`default_nettype wire

// file: verif/dma_rd_port_fsm_tb.sv
// Self-checking bench for the DMA burst-read port state machine
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(64'(got), 64'(exp))
module dma_rd_port_fsm_tb;
    localparam int W_OE = 0, W_CAP = 1, W_SOE = 2, W_REQ = 3, W_QREQ = 4;
    logic                 mclk_i, arst_n_i, addr_select_n_n, target_ready_n_n, comm_sel, bus_oe;
    logic                 cap_n, fin_n, soe, req_n, qreq_n, cmd_valid, cmd_ready;
    logic                 rd_valid, rd_last;
    logic [31:0]          bus_in, bus_out, rd_data;
    dma_rd_pkg::dma_cmd_t cmd;
    logic [31:0]          cap_q[$];
    int                   err_total, samples_checked, words, fin_seen;

    dma_rd_port_fsm i_dma_rd_port_fsm (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_select_n_i(addr_select_n_n),
        .target_ready_n_i(target_ready_n_n), .comm_register_select_i(comm_sel), .port_addr_data_bus_i(bus_in),
        .port_addr_data_bus_o(bus_out), .port_addr_data_bus_oe_o(bus_oe), .capture_strobe_n_o(cap_n),
        .final_transfer_n_o(fin_n), .strobe_oe_o(soe), .dma_request_n_o(req_n), .queued_request_n_o(qreq_n),
        .cmd_i(cmd), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .rd_last_o(rd_last));
    dma_rd_ctrl_model i_dma_rd_ctrl_model (.mclk_i(mclk_i), .bus_oe_i(bus_oe), .bus_dev_i(bus_out),
        .addr_select_n_o(addr_select_n_n), .target_ready_n_o(target_ready_n_n), .comm_register_select_o(comm_sel),
        .bus_o(bus_in));

    // Free-running port clock, 40 ns period
    always #20 mclk_i = ~mclk_i;

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic pick(input int w);
        case (w)
            W_OE:    return bus_oe;
            W_CAP:   return cap_n;
            W_SOE:   return soe;
            W_REQ:   return req_n;
            default: return qreq_n;
        endcase
    endfunction

    // Bounded wait; pin changes need a few edges to cross the synchroniser
    task automatic wait_for(input int w, input logic v);
        int n;
        n = 0;
        #1;
        while (pick(w) !== v && n < 40) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        `CHK(pick(w), v);
    endtask

    // Every captured bus word must come back on rd_data one cycle later
    always @(posedge mclk_i) begin
        if (arst_n_i) begin
            if (cap_n === 1'b0) cap_q.push_back(bus_in);
            if (fin_n === 1'b0) fin_seen++;
            if (fin_n === 1'b0) `CHK(cap_n, 1'b0);
            if (rd_valid === 1'b1) words++;
            if (rd_valid === 1'b1 && cap_q.size() > 0) `CHK(rd_data, cap_q.pop_front());
        end
    end

    task automatic send_cmd(input logic [31:0] a, input logic [15:0] b);
        @(posedge mclk_i);
        cmd       <= '{addr: a, bytes: b};
        cmd_valid <= 1'b1;
        @(negedge mclk_i);
        while (cmd_ready !== 1'b1) @(negedge mclk_i);
        @(posedge mclk_i);
        cmd_valid <= 1'b0;
    endtask

    // One read burst; the pin filter drops one-cycle pulses, so each two-cycle ready pulse steps two words
    task automatic burst(input logic [31:0] a, input int bytes, input bit ad2, input bit queued);
        int  n;
        bit  got_last;
        got_last = 0;
        words    = 0;
        fin_seen = 0;
        i_dma_rd_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
        wait_for(W_OE, 1'b1);
        `CHK(bus_out, a);
        `CHK(cap_n, 1'b1);
        i_dma_rd_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
        wait_for(W_OE, 1'b0);
        wait_for(W_CAP, 1'b0);
        i_dma_rd_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
        wait_for(W_CAP, 1'b1);
        `CHK(bus_oe, 1'b0);
        if (ad2) begin
            i_dma_rd_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
            wait_for(W_OE, 1'b1);
            i_dma_rd_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
            wait_for(W_OE, 1'b0);
        end
        for (n = 0; n < 40 && !got_last; n++) begin
            i_dma_rd_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
            @(posedge mclk_i);
            i_dma_rd_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
            repeat (6) begin
                @(posedge mclk_i);
                #1;
                if (rd_last === 1'b1) got_last = 1;
            end
        end
        @(posedge mclk_i);
        #1;
        `CHK(got_last, 1'b1);
        `CHK(words, (bytes + 3) / 4);
        `CHK(fin_seen, 1);
        `CHK(req_n, !queued);
        `CHK(qreq_n, 1'b1);
        i_dma_rd_ctrl_model.set_pins(1'b0, 1'b1, 1'b0);
        wait_for(W_SOE, 1'b0);
        `CHK(bus_oe, 1'b0);
    endtask

    // No command active: wait hold, comm-select freeze, go without request, then float
    task automatic idle_walk;
        i_dma_rd_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
        wait_for(W_OE, 1'b1);
        i_dma_rd_ctrl_model.set_pins(1'b1, 1'b1, 1'b0);
        wait_for(W_OE, 1'b0);
        repeat (8) @(posedge mclk_i);
        #1;
        `CHK(cap_n, 1'b1);
        i_dma_rd_ctrl_model.set_pins(1'b0, 1'b0, 1'b0);
        wait_for(W_OE, 1'b1);
        // Go arrives with comm select high: the address state must not move
        i_dma_rd_ctrl_model.set_pins(1'b1, 1'b0, 1'b1);
        repeat (10) @(posedge mclk_i);
        #1;
        `CHK(bus_oe, 1'b1);
        i_dma_rd_ctrl_model.set_pins(1'b1, 1'b0, 1'b0);
        wait_for(W_OE, 1'b0);
        wait_for(W_CAP, 1'b0);
        i_dma_rd_ctrl_model.set_pins(1'b0, 1'b1, 1'b0);
        wait_for(W_SOE, 1'b0);
    endtask

    initial begin
        mclk_i    = 1'b0;
        arst_n_i  = 1'b0;
        cmd       = '0;
        cmd_valid = 1'b0;
        repeat (19) @(posedge mclk_i);
        #1;
        `CHK({bus_oe, cap_n, fin_n, soe, req_n, qreq_n, cmd_ready}, 7'h3f);
        @(posedge mclk_i);
        arst_n_i <= 1'b1;
        send_cmd(32'h0000_1000, 16'h003e);
        wait_for(W_REQ, 1'b0);
        send_cmd(32'h0000_8000, 16'h0060);
        wait_for(W_QREQ, 1'b0);
        burst(32'h0000_1000, 62, 1'b0, 1'b1);
        burst(32'h0000_8000, 96, 1'b1, 1'b0);
        idle_walk();
        stop_test();
    end

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
